// ### verilog/fmb_pkg.sv
// shared constants for the move/bank-select execution block
// assumes a core sequencer that supplies one 2-bit quarter-phase code, Q1 to Q4
package fmb_pkg;
	localparam logic [3:0] MOVE_SRC_NIBBLE = 4'hc;
	localparam logic [3:0] MOVE_DST_NIBBLE = 4'hf;
	localparam logic [7:0] BANK_LOAD_OPCODE = 8'h01;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam logic [7:0] BANK_RESET = 8'h00;
	localparam logic [1:0] Q1 = 2'h0;
	localparam logic [1:0] Q2 = 2'h1;
	localparam logic [1:0] Q3 = 2'h2;
	localparam logic [1:0] Q4 = 2'h3;
	typedef enum logic [1:0] {ST_IDLE, ST_MOVE2} fmb_state_t;
endpackage

// ### verilog/fmb_decode.sv
// combinational opcode decoder for the move/bank-select block
// assumes the instruction word is stable for the whole cycle
`timescale 1ns/10ps
module fmb_decode
(
	input wire logic [15:0] instr,
	output logic is_move_first,
	output logic is_move_second,
	output logic is_bank_load
);
	always_comb
	begin
		is_move_first = instr[15:12] == fmb_pkg::MOVE_SRC_NIBBLE;
		is_move_second = instr[15:12] == fmb_pkg::MOVE_DST_NIBBLE;
		is_bank_load = instr[15:8] == fmb_pkg::BANK_LOAD_OPCODE;
	end
endmodule // fmb_decode

// ### verilog/fmb_exec.sv
// execution of the file-to-file move and bank-select literal load
// assumes: qphase and instr come from core logic on sys_clk, instr valid
// from Q1 through Q4; data-space read data returns in the same cycle.
`timescale 1ns/10ps
module fmb_exec
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] qphase,
	input wire logic [15:0] instr,
	input wire logic [7:0] rd_data,
	output logic [11:0] mem_addr,
	output logic rd_en,
	output logic wr_en,
	output logic [7:0] wr_data,
	output logic [7:0] bank_select_register,
	output logic flags_we,
	output logic busy
);
	typedef struct packed {
		fmb_pkg::fmb_state_t state;
		logic [7:0] held_byte;
		logic [7:0] bank;
		logic [11:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdat;
	} fmb_regs_t;

	fmb_regs_t cur_ff;
	fmb_regs_t nxt_cur;
	logic dec_first;
	logic dec_second;
	logic dec_bank;

	////////////////////////////////////////////////////////////////////////
	fmb_decode u_dec
	(
		.instr(instr),
		.is_move_first(dec_first),
		.is_move_second(dec_second),
		.is_bank_load(dec_bank)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_cur.rd = 1'b0;
		nxt_cur.wr = 1'b0;
		unique case (cur_ff.state)
			fmb_pkg::ST_IDLE:
			begin
				if (dec_first && qphase == fmb_pkg::Q1)
				begin
					nxt_cur.addr = instr[11:0];
					nxt_cur.rd = 1'b1;
				end
				if (dec_first && qphase == fmb_pkg::Q2)
					nxt_cur.held_byte = rd_data;
				if (dec_first && qphase == fmb_pkg::Q4)
					nxt_cur.state = fmb_pkg::ST_MOVE2;
				if (dec_bank && qphase == fmb_pkg::Q4)
					nxt_cur.bank = instr[7:0];
			end
			fmb_pkg::ST_MOVE2:
			begin
				if (qphase == fmb_pkg::Q3)
				begin
					nxt_cur.addr = instr[11:0];
					nxt_cur.wdat = cur_ff.held_byte;
					nxt_cur.wr = 1'b1;
				end
				if (qphase == fmb_pkg::Q4)
					nxt_cur.state = fmb_pkg::ST_IDLE;
			end
			default:
				nxt_cur.state = fmb_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cur_ff.state <= fmb_pkg::ST_IDLE;
			cur_ff.held_byte <= 8'h00;
			cur_ff.bank <= fmb_pkg::BANK_RESET;
			cur_ff.addr <= 12'h000;
			cur_ff.rd <= 1'b0;
			cur_ff.wr <= 1'b0;
			cur_ff.wdat <= 8'h00;
		end
		else
			cur_ff <= nxt_cur;
	end

	////////////////////////////////////////////////////////////////////////
	// strobes are registered so they line up with the next quarter phase
	assign mem_addr = cur_ff.addr;
	assign rd_en = cur_ff.rd;
	assign wr_en = cur_ff.wr;
	assign wr_data = cur_ff.wdat;
	assign bank_select_register = cur_ff.bank;
	assign flags_we = 1'b0;
	assign busy = cur_ff.state == fmb_pkg::ST_MOVE2;
endmodule // fmb_exec

// ### test/fmb_exec_chk.sv
// assertions on fmb_exec ports, bound below
// assumes qphase steps once per sys_clk
`timescale 1ns/10ps
module fmb_chk
(
	input logic sys_clk,
	input logic rst,
	input logic [1:0] qphase,
	input logic [15:0] instr,
	input logic rd_en,
	input logic wr_en,
	input logic [7:0] bank_select_register,
	input logic flags_we
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_rd_q2: assert property (rd_en |-> qphase==2'h1) else $error("rd");
	a_rd_op: assert property (rd_en |-> instr[15:12]==4'hc)
		else $error("rd op");
	a_wr_q4: assert property (wr_en |-> qphase==2'h3) else $error("wr");
	a_wr_op: assert property (wr_en |-> instr[15:12]==4'hf)
		else $error("wr op");
	a_wr_pair: assert property (wr_en |-> $past(rd_en,6))
		else $error("pair");
	a_no_flag: assert property (!flags_we) else $error("flags");
	a_bank_q4: assert property ($changed(bank_select_register) |->
		$past(qphase)==2'h3) else $error("bank q");
	a_bank_op: assert property ($changed(bank_select_register) |->
		$past(instr[15:8])==8'h01) else $error("bank op");
	c_move: cover property (wr_en);
	c_read: cover property (rd_en);
	c_bank: cover property ($changed(bank_select_register));
endmodule // fmb_chk
bind fmb_exec fmb_chk chk(.*);

// ### test/tb.sv
// bench for fmb_exec: moves, bank load, lone second word
// assumes qphase is stepped here, one step per sys_clk
`timescale 1ns/10ps
module tb;
	logic sys_clk=0,rst=1,rd_en,wr_en,flags_we,busy;
	logic [1:0] qphase=2'h0;
	logic [15:0] instr=16'h0000;
	logic [7:0] rd_data=8'h00,wr_data,bank_select_register,wd;
	logic [11:0] mem_addr,wa,ra;
	int error_cnt=0,n_checks=0,cyc=0,nw=0,nb=0;
	fmb_exec dut(.*);
	always #5 sys_clk=~sys_clk;
	always @(posedge sys_clk)
	begin
		qphase<=qphase+2'h1;
		if (wr_en) {nw,wa,wd}={nw+1,mem_addr,wr_data};
		if (rd_en) ra=mem_addr;
		nb=nb+int'(busy===1'b1);
		if (++cyc>400) finish_test;
	end
	task automatic cmp(string n,logic [11:0] e,s);
		n_checks++;
		if (s!==e) error_cnt++;
		if (s!==e) $display("Error %s expected %h seen %h",n,e,s);
	endtask
	// word starts at Q1; read data held through the cycle
	task automatic run(logic [15:0] w,logic [7:0] d=8'h00);
		@(posedge sys_clk iff qphase==2'h3);
		{instr,rd_data}<={w,d};
		repeat(3) @(posedge sys_clk);
	endtask
	task automatic t_move;
		run(16'hcfff,8'h5a);
		run(16'hf000);
		run(16'hcfe8,8'hc3);
		run(16'hf001);
		run(16'h0000);
		cmp("dest",12'h001,wa);
		cmp("byte",12'h0c3,{4'h0,wd});
		cmp("writes",12'h002,12'(nw));
		cmp("src",12'hfe8,ra);
		cmp("busy",12'h008,12'(nb));
	endtask
	task automatic t_other;
		run(16'hf123);
		run(16'h01a5);
		run(16'h025a);
		cmp("bank",12'h0a5,{4'h0,bank_select_register});
		cmp("lone",12'h002,12'(nw));
		cmp("lone busy",12'h008,12'(nb));
	endtask
	task automatic finish_test;
		error_cnt+=(cyc>400);
		$display("checks %0d errors %0d",n_checks,error_cnt);
		if (error_cnt==0 && n_checks>0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat(12) @(posedge sys_clk);
		rst<=0;
		t_move;
		t_other;
		finish_test;
	end
endmodule // tb
